//--- hdl/vdc_regs.sv
`include "vdc_defs.svh"

module vdc_regs #(
  parameter int NCH = 4 // Video inputs, at most four
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input vdc_pkg::vdc_stat_t stat_i [NCH],
  output vdc_pkg::vdc_cfg_t cfg_o [NCH]
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  logic take;               // Address phase accepted
  logic wr_ph_ff;           // Write data phase in progress
  logic rd_ph_ff;           // Read wait cycle in progress
  logic [5:0] idx_ff;       // Register index of the data phase
  logic hit_ff;             // Address inside the bank window
  logic [31:0] hrdata_ff;   // Read data register
  logic [1:0] wr_ch;        // Channel of the write
  logic [3:0] wr_reg;       // Register within the channel
  logic wr_en [NCH];        // Write strobe per channel

  // Only NONSEQ or SEQ, when the bus is ready; size is word only
  assign take = hsel_i && htrans_i[1] && hready_i;

  // Phase tracking; hsize is not checked since only words arrive
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
    end else begin
      wr_ph_ff <= take && hwrite_i;
      rd_ph_ff <= take && !hwrite_i;
    end
  end

  // Address latch; byte address is four times the index
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      idx_ff <= 6'h00;
      hit_ff <= 1'b0;
    end else if (take) begin
      idx_ff <= haddr_i[7:2];
      hit_ff <= (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0);
    end
  end

  // Reads take one wait state so a write just before is seen
  assign hreadyout_o = !rd_ph_ff;
  // Always OKAY; unmapped reads return zero, writes are dropped
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;

  // Channel and register of the write in its data phase
  assign wr_ch = idx_ff[5:4];
  assign wr_reg = idx_ff[3:0];

  // ****************************************************************
  // Per-channel storage
  // ****************************************************************

  logic man_ff [NCH];          // Manual standard select
  logic [2:0] fstd_ff [NCH];   // Forced standard
  logic agc_ff [NCH];          // Auto gain enable
  logic ped_ff [NCH];          // Setup level enable
  logic [9:0] hs_ff [NCH];     // Horizontal start
  logic [9:0] hw_ff [NCH];     // Horizontal width
  logic [8:0] vs_ff [NCH];     // Vertical start
  logic [8:0] vh_ff [NCH];     // Vertical height
  logic [7:0] hue_ff [NCH];
  logic [7:0] sat_ff [NCH];
  logic [7:0] con_ff [NCH];
  logic [7:0] brt_ff [NCH];
  logic trapw_ff [NCH];        // Luma trap width
  logic [1:0] comb_ff [NCH];   // Comb mode
  logic pband_ff [NCH];        // Peaking band
  logic [3:0] pgain_ff [NCH];  // Peaking gain
  logic [2:0] std_ff [NCH];    // Standard actually in use

  // Strobe per channel; channels past NCH are unmapped
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wr_en[c] = wr_ph_ff && hit_ff && (wr_ch == 2'(c));
    end
  end

  // Control and status register, writable part
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        man_ff[c] <= 1'b0;
        fstd_ff[c] <= 3'h0;
        agc_ff[c] <= 1'b0;
        ped_ff[c] <= 1'b0;
      end else if (wr_en[c] && wr_reg == `VDC_IDX_CTRL) begin
        // Read-only flags in bits 1:0 are not stored
        man_ff[c] <= hwdata_i[`VDC_CTRL_MAN];
        fstd_ff[c] <= hwdata_i[`VDC_CTRL_FSTD_LO +: 3];
        agc_ff[c] <= hwdata_i[`VDC_CTRL_AGC];
        ped_ff[c] <= hwdata_i[`VDC_CTRL_PED];
      end
    end
  end

  // Cropping window; low bytes and shared upper bits
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        hs_ff[c] <= `VDC_RST_HSTART;
        hw_ff[c] <= `VDC_RST_HWIDTH;
        vs_ff[c] <= `VDC_RST_VSTART;
        vh_ff[c] <= `VDC_RST_VHEIGHT;
      end else if (wr_en[c]) begin
        case (wr_reg)
          `VDC_IDX_HSTART: begin
            hs_ff[c][7:0] <= hwdata_i[7:0];
          end
          `VDC_IDX_HWIDTH: begin
            hw_ff[c][7:0] <= hwdata_i[7:0];
          end
          `VDC_IDX_VSTART: begin
            vs_ff[c][7:0] <= hwdata_i[7:0];
          end
          `VDC_IDX_VHEIGHT: begin
            vh_ff[c][7:0] <= hwdata_i[7:0];
          end
          `VDC_IDX_WINHI: begin
            // Bits 7:6 are not stored
            vh_ff[c][8] <= hwdata_i[`VDC_WIN_VH8];
            vs_ff[c][8] <= hwdata_i[`VDC_WIN_VS8];
            hw_ff[c][9:8] <= hwdata_i[`VDC_WIN_HW_LO +: 2];
            hs_ff[c][9:8] <= hwdata_i[`VDC_WIN_HS_LO +: 2];
          end
          default: begin
            // Other registers are not part of the window
          end
        endcase
      end
    end
  end

  // Picture adjustments; 128 is the neutral point of each
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        hue_ff[c] <= `VDC_RST_MID;
        sat_ff[c] <= `VDC_RST_MID;
        con_ff[c] <= `VDC_RST_MID;
        brt_ff[c] <= `VDC_RST_MID;
      end else if (wr_en[c]) begin
        case (wr_reg)
          `VDC_IDX_HUE: begin
            hue_ff[c] <= hwdata_i[7:0];
          end
          `VDC_IDX_SAT: begin
            sat_ff[c] <= hwdata_i[7:0];
          end
          `VDC_IDX_CONTRAST_ADJUST: begin
            con_ff[c] <= hwdata_i[7:0];
          end
          `VDC_IDX_BRT: begin
            brt_ff[c] <= hwdata_i[7:0];
          end
          default: begin
            // Not an adjustment register
          end
        endcase
      end
    end
  end

  // Luma filter control
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        trapw_ff[c] <= 1'b0;
        comb_ff[c] <= 2'h0;
        pband_ff[c] <= 1'b0;
        pgain_ff[c] <= 4'h0;
      end else if (wr_en[c] && wr_reg == `VDC_IDX_LUMA) begin
        trapw_ff[c] <= hwdata_i[`VDC_LUMA_TRAPW];
        comb_ff[c] <= hwdata_i[`VDC_LUMA_COMB_LO +: 2];
        pband_ff[c] <= hwdata_i[`VDC_LUMA_PBAND];
        pgain_ff[c] <= hwdata_i[`VDC_LUMA_PGAIN_LO +: 4];
      end
    end
  end

  // Standard in use; forced also serves as free-run with no video
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (!rstn_i) begin
        std_ff[c] <= 3'h0;
      end else if (man_ff[c] || !stat_i[c].video_present) begin
        std_ff[c] <= fstd_ff[c];
      end else begin
        std_ff[c] <= stat_i[c].detected_std;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  logic [7:0] rd_val;  // Selected register byte
  logic [1:0] rd_ch;   // Channel being read
  int rd_c;            // Channel as an array index

  assign rd_ch = idx_ff[5:4];
  assign rd_c = int'(rd_ch);

  // Read mux; unmapped indices and channels read zero
  always_comb begin
    rd_val = 8'h00;
    if (hit_ff && rd_c < NCH) begin
      case (idx_ff[3:0])
        `VDC_IDX_CTRL: begin
          // Live flags straight from the detector
          rd_val = {man_ff[rd_c], fstd_ff[rd_c], agc_ff[rd_c], ped_ff[rd_c],
                    stat_i[rd_c].nonstandard, stat_i[rd_c].field_60};
        end
        `VDC_IDX_HSTART: begin
          rd_val = hs_ff[rd_c][7:0];
        end
        `VDC_IDX_HWIDTH: begin
          rd_val = hw_ff[rd_c][7:0];
        end
        `VDC_IDX_VSTART: begin
          rd_val = vs_ff[rd_c][7:0];
        end
        `VDC_IDX_VHEIGHT: begin
          rd_val = vh_ff[rd_c][7:0];
        end
        `VDC_IDX_WINHI: begin
          rd_val = {2'h0, vh_ff[rd_c][8], vs_ff[rd_c][8],
                    hw_ff[rd_c][9:8], hs_ff[rd_c][9:8]};
        end
        `VDC_IDX_HUE: begin
          rd_val = hue_ff[rd_c];
        end
        `VDC_IDX_SAT: begin
          rd_val = sat_ff[rd_c];
        end
        `VDC_IDX_CONTRAST_ADJUST: begin
          rd_val = con_ff[rd_c];
        end
        `VDC_IDX_BRT: begin
          rd_val = brt_ff[rd_c];
        end
        `VDC_IDX_LUMA: begin
          rd_val = {trapw_ff[rd_c], comb_ff[rd_c], pband_ff[rd_c], pgain_ff[rd_c]};
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
  end

  // Read data is caught in the wait cycle and then held
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_ph_ff) begin
      hrdata_ff <= {24'h000000, rd_val};
    end
  end

  // ****************************************************************
  // Settings to the decoder channels
  // ****************************************************************

  // Field mapping plus the comb decode; every value comes from a flop above
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cfg_o[c].std_sel = vdc_pkg::vdc_std_t'(std_ff[c]);
      cfg_o[c].agc_run = agc_ff[c];
      cfg_o[c].setup_level = ped_ff[c];
      cfg_o[c].h_start = hs_ff[c];
      cfg_o[c].h_width = hw_ff[c];
      cfg_o[c].v_start = vs_ff[c];
      cfg_o[c].v_height = vh_ff[c];
      cfg_o[c].hue = hue_ff[c];
      cfg_o[c].saturation_gain = sat_ff[c];
      cfg_o[c].contrast_gain = con_ff[c];
      cfg_o[c].brightness_offset = brt_ff[c];
      cfg_o[c].luma_trap_width = trapw_ff[c];
      // Unsupported code 3 keeps the adaptive comb, the safer choice
      cfg_o[c].trap_forced =
        (vdc_pkg::vdc_comb_t'(comb_ff[c]) == vdc_pkg::VDC_COMB_TRAP);
      cfg_o[c].peaking_band = pband_ff[c];
      cfg_o[c].peaking_gain = pgain_ff[c];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_manual_std;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    man_ff[0] |=> cfg_o[0].std_sel == vdc_pkg::vdc_std_t'($past(fstd_ff[0]));
  endproperty
  a_manual_std: assert property (p_manual_std) else $error("forced std not used");

  property p_auto_std;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (!man_ff[0] && stat_i[0].video_present) |=>
      std_ff[0] == $past(stat_i[0].detected_std);
  endproperty
  a_auto_std: assert property (p_auto_std) else $error("detected std not used");

  property p_window_reset;
    @(posedge clk_sys_i)
    !rstn_i |=> hs_ff[0] == 10'h020 && hw_ff[0] == 10'h2D0 &&
               vs_ff[0] == 9'h006 && vh_ff[0] == 9'h0F0;
  endproperty
  a_window_reset: assert property (p_window_reset) else $error("window reset wrong");

  property p_ctrl_flags;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_ph_ff && hit_ff && idx_ff == 6'h21 && NCH > 2) |=>
      hrdata_o[1:0] == {$past(stat_i[2 % NCH].nonstandard), $past(stat_i[2 % NCH].field_60)};
  endproperty
  a_ctrl_flags: assert property (p_ctrl_flags) else $error("flag read wrong");

  property p_winhi_read;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_ph_ff && hit_ff && idx_ff[3:0] == 4'h6) |=> hrdata_o[31:6] == 26'h0000000;
  endproperty
  a_winhi_read: assert property (p_winhi_read) else $error("window high bits");

  property p_read_wait;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (take && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

  property p_hue_write;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_ph_ff && hit_ff && idx_ff == 6'h17) |=>
      cfg_o[1 % NCH].hue == $past(hwdata_i[7:0]) || NCH < 2;
  endproperty
  a_hue_write: assert property (p_hue_write) else $error("channel hue write");

  property p_comb_trap;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_ph_ff && hit_ff && idx_ff == 6'h0B) |=>
      cfg_o[0].trap_forced == ($past(hwdata_i[6:5]) == 2'h2);
  endproperty
  a_comb_trap: assert property (p_comb_trap) else $error("comb decode wrong");

  property p_adjust_reset;
    @(posedge clk_sys_i)
    !rstn_i ##1 rstn_i |-> cfg_o[0].hue == 8'h80 && cfg_o[0].contrast_gain == 8'h80 &&
      cfg_o[0].peaking_gain == 4'h0 && !cfg_o[0].agc_run;
  endproperty
  a_adjust_reset: assert property (p_adjust_reset) else $error("adjust reset wrong");

endmodule

//--- include/vdc_defs.svh
`ifndef VDC_DEFS_SVH
`define VDC_DEFS_SVH

// ****************************************************************
// Register indices inside one channel block
// ****************************************************************
`define VDC_IDX_CTRL      4'h1  // Standard control and status
`define VDC_IDX_HSTART    4'h2  // Horizontal start, low byte
`define VDC_IDX_HWIDTH    4'h3  // Horizontal width, low byte
`define VDC_IDX_VSTART    4'h4  // Vertical start, low byte
`define VDC_IDX_VHEIGHT   4'h5  // Vertical height, low byte
`define VDC_IDX_WINHI     4'h6  // Upper bits of the window values
`define VDC_IDX_HUE       4'h7  // Hue adjust
`define VDC_IDX_SAT       4'h8  // Saturation adjust
`define VDC_IDX_CONTRAST_ADJUST      4'h9  // Contrast adjust
`define VDC_IDX_BRT       4'hA  // Brightness adjust
`define VDC_IDX_LUMA      4'hB  // Luma filter control
`define VDC_CH_STRIDE     6'h10 // Index step between channels

// ****************************************************************
// Field positions
// ****************************************************************
`define VDC_CTRL_MAN      7     // Manual standard select
`define VDC_CTRL_FSTD_LO  4     // Forced standard, 3 bits
`define VDC_CTRL_AGC      3     // Auto gain enable
`define VDC_CTRL_PED      2     // Setup level enable
`define VDC_CTRL_NONSTD   1     // Nonstandard flag, read only
`define VDC_CTRL_FLD60    0     // Field rate flag, read only
`define VDC_WIN_VH8       5     // Height bit 8
`define VDC_WIN_VS8       4     // Vertical start bit 8
`define VDC_WIN_HW_LO     2     // Width bits 9:8
`define VDC_WIN_HS_LO     0     // Horizontal start bits 9:8
`define VDC_LUMA_TRAPW    7     // Luma trap width
`define VDC_LUMA_COMB_LO  5     // Comb mode, 2 bits
`define VDC_LUMA_PBAND    4     // Peaking band
`define VDC_LUMA_PGAIN_LO 0     // Peaking gain, 4 bits

// ****************************************************************
// Reset values
// ****************************************************************
`define VDC_RST_HSTART    10'h020
`define VDC_RST_HWIDTH    10'h2D0
`define VDC_RST_VSTART    9'h006
`define VDC_RST_VHEIGHT   9'h0F0
`define VDC_RST_MID       8'h80  // Hue, saturation, contrast, brightness

`endif

//--- include/vdc_pkg.sv
package vdc_pkg;

  // ****************************************************************
  // Types shared by the register bank and its users
  // ****************************************************************

  // Video standards, in field encoding order
  typedef enum logic [2:0] {
    VDC_STD_PAL_BD, VDC_STD_PAL_M, VDC_STD_PAL_N, VDC_STD_PAL_60,
    VDC_STD_NTSC_M, VDC_STD_NTSC_443, VDC_STD_NTSC_N, VDC_STD_RSVD
  } vdc_std_t;

  // Comb filter modes, in field encoding order
  typedef enum logic [1:0] {
    VDC_COMB_ADAPT0, VDC_COMB_ADAPT1, VDC_COMB_TRAP, VDC_COMB_UNSUP
  } vdc_comb_t;

  // Detector status coming from one decoder channel
  typedef struct packed {
    logic [2:0] detected_std;  // Standard found by detection
    logic       video_present; // Video seen on the input
    logic       nonstandard;   // Source is non-standard
    logic       field_60;      // 1: 60 Hz, 0: 50 Hz
  } vdc_stat_t;

  // Settings driven into one decoder channel
  typedef struct packed {
    vdc_std_t   std_sel;       // Standard in use
    logic       agc_run;       // Gain loop allowed to run
    logic       setup_level;   // 7.5 IRE pedestal maps to code 16
    logic [9:0] h_start;
    logic [9:0] h_width;
    logic [8:0] v_start;
    logic [8:0] v_height;
    logic [7:0] hue;
    logic [7:0] saturation_gain;
    logic [7:0] contrast_gain;
    logic [7:0] brightness_offset;
    logic       luma_trap_width;
    logic       trap_forced;   // Comb bypassed, trap filter used
    logic       peaking_band;
    logic [3:0] peaking_gain;
  } vdc_cfg_t;

endpackage

//--- verification/test_video_decoder_channel_controls.sv
`include "vdc_defs.svh"

module test_video_decoder_channel_controls;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Clock, reset and bus signals
  // ****************************************************************
  logic clk_sys_i = 1'b0; // 100 MHz system clock
  logic rstn_i = 1'b0; // Active low reset
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready; // Slave hreadyout fed back as bus hready
  logic hresp;
  logic [31:0] hrdata;
  vdc_pkg::vdc_stat_t stat [4] = '{default: '0}; // Detector status per input
  vdc_pkg::vdc_cfg_t cfg [4]; // Settings per input
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0; // Cycles since start, for the hang guard
  logic [31:0] rdv; // Last read word
  logic [7:0] rst_val [16] = '{8'h00, 8'h00, 8'h20, 8'hD0, 8'h06, 8'hF0, 8'h08, 8'h80,
    8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}; // Read value by index

  always #5 clk_sys_i = ~clk_sys_i;

  vdc_regs #(.NCH(4)) DUT (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .hsel_i(hsel),
    .haddr_i(haddr),
    .htrans_i(htrans),
    .hwrite_i(hwrite),
    .hsize_i(3'h2),
    .hwdata_i(hwdata),
    .hready_i(hready),
    .hreadyout_o(hready),
    .hresp_o(hresp),
    .hrdata_o(hrdata),
    .stat_i(stat),
    .cfg_o(cfg)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One single AHB transfer; the wait loops rely on the hang guard
  task automatic xfer(input logic [1:0] ch, input logic [3:0] idx, input logic w,
      input logic [7:0] wd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h0, ch, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    rdv = hrdata;
    chk(hresp, 1'b0); // Slave always answers OKAY
  endtask

  task automatic wr(input logic [1:0] ch, input logic [3:0] idx, input logic [7:0] d);
    xfer(ch, idx, 1'b1, d);
  endtask

  task automatic rd(input logic [1:0] ch, input logic [3:0] idx, input logic [7:0] exp);
    xfer(ch, idx, 1'b0, 8'h00);
    chk(rdv, {24'h0, exp});
  endtask

  // Let the standard select settle: it lags the register by one cycle
  // Ends on an edge, so detector inputs can change there by NBA
  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1;
    // Reset values, all channels; unmapped indices read zero
    for (int c = 0; c < 4; c++) begin
      chk({cfg[c].std_sel, cfg[c].agc_run, cfg[c].setup_level}, 5'h00);
      chk({cfg[c].h_start, cfg[c].h_width}, {10'h020, 10'h2D0});
      chk({cfg[c].v_start, cfg[c].v_height}, {9'h006, 9'h0F0});
      chk({cfg[c].hue, cfg[c].saturation_gain}, 16'h8080);
      chk({cfg[c].contrast_gain, cfg[c].brightness_offset}, 16'h8080);
      chk({cfg[c].luma_trap_width, cfg[c].trap_forced}, 2'h0);
      chk({cfg[c].peaking_band, cfg[c].peaking_gain}, 5'h00);
      for (int i = 0; i < 16; i++) begin
        rd(c[1:0], i[3:0], rst_val[i]);
      end
    end
    $display("test reset_values done");

    // Window values with their upper bits; bits 7:6 read zero
    wr(1, `VDC_IDX_HSTART, 8'h34);
    wr(1, `VDC_IDX_HWIDTH, 8'h56);
    wr(1, `VDC_IDX_VSTART, 8'h78);
    wr(1, `VDC_IDX_VHEIGHT, 8'h9A);
    wr(1, `VDC_IDX_WINHI, 8'hFF);
    rd(1, `VDC_IDX_WINHI, 8'h3F);
    #1;
    chk({cfg[1].h_start, cfg[1].h_width}, {10'h334, 10'h356});
    chk({cfg[1].v_start, cfg[1].v_height}, {9'h178, 9'h19A});
    wr(1, `VDC_IDX_WINHI, 8'h24);
    #1;
    chk({cfg[1].h_start, cfg[1].h_width}, {10'h034, 10'h156});
    chk({cfg[1].v_start, cfg[1].v_height}, {9'h078, 9'h19A});
    rd(0, `VDC_IDX_WINHI, 8'h08);
    wr(1, `VDC_IDX_HUE, 8'h5C);
    rd(1, `VDC_IDX_HUE, 8'h5C);
    $display("test window done");

    // Forced standard codes 0 to 6, then detection and free-run
    for (int s = 0; s < 7; s++) begin
      wr(0, `VDC_IDX_CTRL, {1'b1, s[2:0], 4'h0});
      settle();
      chk(cfg[0].std_sel, s[2:0]);
    end
    stat[0].detected_std <= 3'h5;
    stat[0].video_present <= 1'b1;
    wr(0, `VDC_IDX_CTRL, 8'h20);
    settle();
    chk(cfg[0].std_sel, 3'h5);
    stat[0].video_present <= 1'b0;
    settle();
    chk(cfg[0].std_sel, 3'h2);
    wr(0, `VDC_IDX_CTRL, 8'h0C);
    settle();
    chk({cfg[0].std_sel, cfg[0].agc_run, cfg[0].setup_level}, 5'h03);
    wr(0, `VDC_IDX_CTRL, 8'h04);
    settle();
    chk({cfg[0].agc_run, cfg[0].setup_level}, 2'h1);
    $display("test standard done");

    // Read-only flags follow the detector; writes leave them alone
    stat[2].nonstandard <= 1'b1;
    stat[2].field_60 <= 1'b1;
    wr(2, `VDC_IDX_CTRL, 8'h80);
    rd(2, `VDC_IDX_CTRL, 8'h83);
    stat[2].nonstandard <= 1'b0;
    wr(2, `VDC_IDX_CTRL, 8'h03);
    rd(2, `VDC_IDX_CTRL, 8'h01);
    stat[2].field_60 <= 1'b0;
    rd(2, `VDC_IDX_CTRL, 8'h00);
    $display("test status_flags done");

    // Picture adjustments on one channel only
    wr(3, `VDC_IDX_HUE, 8'h00);
    wr(3, `VDC_IDX_SAT, 8'hFF);
    wr(3, `VDC_IDX_CONTRAST_ADJUST, 8'h01);
    wr(3, `VDC_IDX_BRT, 8'h7F);
    rd(3, `VDC_IDX_SAT, 8'hFF);
    #1;
    chk({cfg[3].hue, cfg[3].saturation_gain}, 16'h00FF);
    chk({cfg[3].contrast_gain, cfg[3].brightness_offset}, 16'h017F);
    chk({cfg[2].hue, cfg[2].brightness_offset}, 16'h8080);
    rd(2, `VDC_IDX_HUE, 8'h80);
    $display("test adjust done");

    // Luma filter: all comb modes, wide trap, low band, full gain
    for (int m = 0; m < 4; m++) begin
      wr(0, `VDC_IDX_LUMA, {1'b1, m[1:0], 1'b1, 4'hF});
      rd(0, `VDC_IDX_LUMA, {1'b1, m[1:0], 1'b1, 4'hF});
      #1;
      chk({cfg[0].luma_trap_width, cfg[0].trap_forced}, {1'b1, m == 2});
      chk({cfg[0].peaking_band, cfg[0].peaking_gain}, 5'h1F);
    end
    wr(0, `VDC_IDX_LUMA, 8'h03);
    #1;
    chk({cfg[0].luma_trap_width, cfg[0].peaking_band, cfg[0].peaking_gain}, 6'h03);
    $display("test luma done");

    // Unmapped indices drop writes and read zero
    wr(1, 4'hC, 8'hA5);
    rd(1, 4'hC, 8'h00);
    wr(0, 4'h0, 8'h5A);
    rd(0, 4'h0, 8'h00);
    $display("test unmapped done");
    conclude();
  end
endmodule
